// ### drtw_defs.vh
// constants for the dual reload timer with waveform output
`ifndef DRTW_DEFS_VH
`define DRTW_DEFS_VH
`define DRTW_ADDR_W 12
`define DRTW_OFF_RUN 12'h108
`define DRTW_OFF_ONESHOT 12'h109
`define DRTW_OFF_PINCTL 12'h10A
`define DRTW_OFF_MODE 12'h10B
`define DRTW_OFF_PRESCALE 12'h10C
`define DRTW_OFF_SECONDARY 12'h10D
`define DRTW_OFF_PRIMARY 12'h10E
`define DRTW_RUN_START 0
`define DRTW_RUN_STATUS 1
`define DRTW_RUN_HALT 2
`define DRTW_PIN_LEVEL 0
`define DRTW_PIN_ROUTE 1
`define DRTW_MODE_LO 0
`define DRTW_MODE_HI 1
`define DRTW_MODE_WTHRU 3
`define DRTW_SRC_LO 4
`define DRTW_SRC_HI 5
`define DRTW_MODE_TIMER 2'b00
`define DRTW_MODE_WAVE 2'b01
`define DRTW_SRC_DIV1 2'b00
`define DRTW_SRC_DIV8 2'b01
`define DRTW_SRC_COMP 2'b10
`define DRTW_SRC_DIV2 2'b11
`define DRTW_PIN_MASK 8'h0F
`define DRTW_MODE_MASK 8'hFB
`define DRTW_ZERO8 8'h00
`define DRTW_DIV8_LAST 3'h7
`endif

// ### drtw_timer.v
// dual reload timer with programmable waveform output
// Notes on behaviour
// - prescaler clocked by div1, div2, div8 or companion
// - main counts prescaler underflows; separate reload registers
// - timer mode reloads primary on each underflow
// - writing start bit one begins counting
// - start bit zero or halt bit stops counting
// - timer mode interrupt at every main underflow, except one that meets a pending write-through transfer
// - timer mode ignores oneshot and secondary registers
// - reads return live counter values
// - stopped prescaler and primary writes load reload and counter, except primary during a wave secondary period
// - running timer writes obey write-through select
// - counter transfers wait for source or underflow
// - wave mode primary first, then alternate, toggle output
// - periods are (n+1)(m+1) and (n+1)(p+1) source cycles
// - wave interrupt with output change after secondary
// - wave running writes hit reload registers only
// - level select sets pin level per period
// - route select picks pulse or port latch
// - route select sampled at start or interrupt
// - secondary count readable at the primary address during secondary period
// - pin control upper four bits read zero
// - mode 00 timer, 01 waveform
// - source 00 div1, 01 div8, 10 companion, 11 div2
// - halt bit stops at once, reads zero
`include "drtw_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module drtw_timer #(
    parameter CNT_W = 8
) (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // register port
    input wire [`DRTW_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // count sources and port latch
    input wire companion_underflow,
    input wire port_latch_bit,
    // outputs
    output reg pulse_output_pin,
    output reg timer_irq
);
    // reset release through two flops; assertion stays asynchronous
    wire rst_i_n;
    drtw_sync2 u_rst_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .d(1'b1),
        .q(rst_i_n)
    );

    // companion underflow arrives from another block; synchronise and edge detect
    wire comp_s2;
    reg comp_s3;
    drtw_sync2 u_comp_sync (
        .core_clk(core_clk),
        .rst_n(rst_i_n),
        .d(companion_underflow),
        .q(comp_s2)
    );
    // edge detector resets low, the idle level of the source
    always @(posedge core_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            comp_s3 <= 1'b0;
        end else begin
            comp_s3 <= comp_s2;
        end
    end

    // port latch value comes from pin logic outside this clock domain
    wire latch_s2;
    drtw_sync2 u_latch_sync (
        .core_clk(core_clk),
        .rst_n(rst_i_n),
        .d(port_latch_bit),
        .q(latch_s2)
    );

    // software-visible registers
    reg run_start_bit;
    reg counting_status_flag;
    reg [7:0] output_pin_control;
    reg [7:0] mode_select_reg;
    reg [7:0] oneshot_control_reg;
    // reload registers and live counters
    reg [CNT_W-1:0] pre_reload;
    reg [CNT_W-1:0] pri_reload;
    reg [CNT_W-1:0] sec_reload;
    reg [CNT_W-1:0] pre_cnt;
    reg [CNT_W-1:0] main_cnt;
    // write-through transfers waiting for their sync event
    reg pre_pend;
    reg main_pend;
    // waveform state
    reg in_secondary;
    reg wave_level;
    reg route_live;
    reg half_pend;
    // divided clock state
    reg [2:0] div_cnt;
    reg div2_t;

    wire [1:0] mode = {mode_select_reg[`DRTW_MODE_HI], mode_select_reg[`DRTW_MODE_LO]};
    wire [1:0] src = {mode_select_reg[`DRTW_SRC_HI], mode_select_reg[`DRTW_SRC_LO]};
    wire wave_mode = (mode == `DRTW_MODE_WAVE);
    wire wthru = mode_select_reg[`DRTW_MODE_WTHRU];

    // divide-by-eight tick counter
    always @(posedge core_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            div_cnt <= 3'h0;
        end else begin
            div_cnt <= div_cnt + 3'h1;
        end
    end
    // divide-by-two toggle
    always @(posedge core_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            div2_t <= 1'b0;
        end else begin
            div2_t <= ~div2_t;
        end
    end
    reg src_tick;
    always @* begin
        case (src)
            `DRTW_SRC_DIV1: src_tick = 1'b1;
            `DRTW_SRC_DIV8: src_tick = (div_cnt == `DRTW_DIV8_LAST);
            `DRTW_SRC_COMP: src_tick = comp_s2 & ~comp_s3;
            `DRTW_SRC_DIV2: src_tick = div2_t;
            default: src_tick = 1'b0;
        endcase
    end

    // register write decode
    wire wr_run = reg_wr && reg_addr == `DRTW_OFF_RUN;
    wire wr_oneshot = reg_wr && reg_addr == `DRTW_OFF_ONESHOT;
    wire wr_pin = reg_wr && reg_addr == `DRTW_OFF_PINCTL;
    wire wr_mode = reg_wr && reg_addr == `DRTW_OFF_MODE;
    wire wr_pre = reg_wr && reg_addr == `DRTW_OFF_PRESCALE;
    wire wr_sec = reg_wr && reg_addr == `DRTW_OFF_SECONDARY;
    wire wr_pri = reg_wr && reg_addr == `DRTW_OFF_PRIMARY;
    wire halt_req = wr_run && reg_wdata[`DRTW_RUN_HALT];
    wire counting = counting_status_flag && !halt_req;
    wire stopped = !counting_status_flag;
    // write-through only in timer mode with select clear
    wire wr_thru = !wave_mode && !wthru;

    // status flag moves on a source tick except at halt, so start and stop
    // by the start bit are aligned to the count source
    wire flag_change = !halt_req && src_tick && counting_status_flag != run_start_bit;
    wire start_evt = flag_change && run_start_bit;

    wire pre_uf = counting && src_tick && pre_cnt == `DRTW_ZERO8;
    wire main_uf = pre_uf && main_cnt == `DRTW_ZERO8;
    wire wave_uf = main_uf && wave_mode;
    // primary values taken at end of secondary period, so new values
    // start with the following primary period
    wire [CNT_W-1:0] main_next_reload = (wave_mode && !in_secondary) ? sec_reload : pri_reload;

    // output change and wave interrupt fall on the first source tick after underflow
    wire half_fire = half_pend && src_tick;
    wire wave_irq = half_fire && !in_secondary;
    wire timer_uf_irq = main_uf && !wave_mode && !main_pend;
    wire next_wave_level = half_fire ? in_secondary : (start_evt ? 1'b0 : wave_level);
    wire next_route = (start_evt || wave_irq) ? output_pin_control[`DRTW_PIN_ROUTE] : route_live;
    // pin built from next state so it moves on the same edge as the interrupt
    wire pulse_level = next_wave_level ^ output_pin_control[`DRTW_PIN_LEVEL];
    wire pin_next = (wave_mode && !next_route) ? pulse_level : latch_s2;

    // run control
    always @(posedge core_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            run_start_bit <= 1'b0;
            counting_status_flag <= 1'b0;
        end else begin
            if (wr_run) begin
                if (reg_wdata[`DRTW_RUN_HALT]) begin
                    run_start_bit <= 1'b0;
                end else begin
                    run_start_bit <= reg_wdata[`DRTW_RUN_START];
                end
            end
            if (halt_req) begin
                counting_status_flag <= 1'b0;
            end else if (flag_change) begin
                counting_status_flag <= run_start_bit;
            end
        end
    end

    // control registers
    always @(posedge core_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            output_pin_control <= `DRTW_ZERO8;
            mode_select_reg <= `DRTW_ZERO8;
            oneshot_control_reg <= `DRTW_ZERO8;
        end else begin
            if (wr_pin) begin
                output_pin_control <= reg_wdata & `DRTW_PIN_MASK;
            end
            if (wr_mode) begin
                mode_select_reg <= reg_wdata & `DRTW_MODE_MASK;
            end
            // kept for the one-shot modes only; no effect here
            if (wr_oneshot) begin
                oneshot_control_reg <= reg_wdata;
            end
        end
    end

    // prescaler
    always @(posedge core_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            pre_reload <= {CNT_W{1'b1}};
            pre_cnt <= {CNT_W{1'b1}};
            pre_pend <= 1'b0;
        end else begin
            if (wr_pre) begin
                pre_reload <= reg_wdata[CNT_W-1:0];
                if (stopped) begin
                    pre_cnt <= reg_wdata[CNT_W-1:0];
                end else if (wr_thru) begin
                    pre_pend <= 1'b1;
                end
            end
            if (counting && src_tick) begin
                if (pre_pend || pre_cnt == `DRTW_ZERO8) begin
                    pre_cnt <= pre_reload;
                    if (!wr_pre) begin
                        pre_pend <= 1'b0;
                    end
                end else begin
                    pre_cnt <= pre_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // main counter
    always @(posedge core_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            pri_reload <= {CNT_W{1'b1}};
            sec_reload <= {CNT_W{1'b1}};
            main_cnt <= {CNT_W{1'b1}};
            main_pend <= 1'b0;
        end else begin
            if (wr_pri) begin
                pri_reload <= reg_wdata[CNT_W-1:0];
                if (stopped && !(wave_mode && in_secondary)) begin
                    main_cnt <= reg_wdata[CNT_W-1:0];
                end else if (!stopped && wr_thru) begin
                    main_pend <= 1'b1;
                end
            end
            if (wr_sec) begin
                sec_reload <= reg_wdata[CNT_W-1:0];
            end
            if (pre_uf) begin
                if (main_pend && !wave_mode) begin
                    main_cnt <= pri_reload;
                    if (!wr_pri) begin
                        main_pend <= 1'b0;
                    end
                end else if (main_cnt == `DRTW_ZERO8) begin
                    main_cnt <= main_next_reload;
                end else begin
                    main_cnt <= main_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
            // a stale primary write-through must not survive a timer-mode stop
            if (stopped && !wave_mode) begin
                main_pend <= 1'b0;
            end
        end
    end

    // which reload the next underflow takes, and the pending output change
    always @(posedge core_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            in_secondary <= 1'b0;
            half_pend <= 1'b0;
        end else begin
            if (start_evt) begin
                in_secondary <= 1'b0;
            end else if (wave_uf) begin
                in_secondary <= ~in_secondary;
            end
            if (half_fire || !counting) begin
                half_pend <= 1'b0;
            end else if (wave_uf) begin
                half_pend <= 1'b1;
            end
        end
    end

    // waveform level, route and pin
    always @(posedge core_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            wave_level <= 1'b0;
            route_live <= 1'b0;
            pulse_output_pin <= 1'b0;
        end else begin
            wave_level <= next_wave_level;
            route_live <= next_route;
            pulse_output_pin <= pin_next;
        end
    end

    // interrupt request, one cycle per event
    always @(posedge core_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= timer_uf_irq || wave_irq;
        end
    end

    // reads give live counters
    reg [7:0] next_rdata;
    always @* begin
        next_rdata = `DRTW_ZERO8;
        if (reg_rd) begin
            case (reg_addr)
                `DRTW_OFF_RUN: next_rdata = {5'h0, 1'b0, counting_status_flag, run_start_bit};
                `DRTW_OFF_ONESHOT: next_rdata = oneshot_control_reg;
                `DRTW_OFF_PINCTL: next_rdata = output_pin_control;
                `DRTW_OFF_MODE: next_rdata = mode_select_reg;
                `DRTW_OFF_PRESCALE: next_rdata = pre_cnt;
                `DRTW_OFF_SECONDARY: next_rdata = sec_reload;
                `DRTW_OFF_PRIMARY: next_rdata = main_cnt;
                default: next_rdata = `DRTW_ZERO8;
            endcase
        end
    end
    always @(posedge core_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            reg_rdata <= `DRTW_ZERO8;
        end else begin
            reg_rdata <= next_rdata;
        end
    end
endmodule // drtw_timer

// two flip-flop synchroniser; only the second stage is read outside
module drtw_sync2 (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // signal
    input wire d,
    output reg q
);
    reg meta;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // drtw_sync2
`default_nettype wire

// ### drtw_timer_assertions.sv
// assertion checker for the dual reload timer ports
`timescale 1ns/1ps
`default_nettype none
`include "drtw_defs.vh"
module drtw_timer_assertions (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // pins
    input wire logic port_latch_bit,
    input wire logic pulse_output_pin,
    input wire logic timer_irq
);
    logic [1:0] mode_q;
    logic run_q;
    logic [4:0] idle;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // shadow copies of software state, since only the pins are visible here
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= 2'h0;
            run_q <= 1'b0;
            idle <= 5'h00;
        end else begin
            if (reg_wr && reg_addr == `DRTW_OFF_MODE) mode_q <= reg_wdata[1:0];
            if (reg_wr && reg_addr == `DRTW_OFF_RUN) run_q <= reg_wdata[0] & ~reg_wdata[2];
            idle <= run_q ? 5'h00 : idle + {4'h0, idle != 5'h14};
        end
    end
    sequence s_rd(a); $past(reg_rd && reg_addr == a); endsequence
    // latch must settle through its synchroniser first
    sequence s_calm; (mode_q == 2'h0 && $stable(port_latch_bit)) [*4]; endsequence
    property p_rd_quiet; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data not idle");
    property p_pin_hi; s_rd(`DRTW_OFF_PINCTL) |-> reg_rdata[7:4] == 4'h0; endproperty
    a_pin_hi: assert property (p_pin_hi) else $error("pin control high bits set");
    property p_run_rd; s_rd(`DRTW_OFF_RUN) |-> reg_rdata[7:2] == 6'h00; endproperty
    a_run_rd: assert property (p_run_rd) else $error("run control read bad");
    property p_mode_rd; s_rd(`DRTW_OFF_MODE) |-> !reg_rdata[2]; endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("mode bit two set");
    property p_halt; reg_wr && reg_addr == `DRTW_OFF_RUN && reg_wdata[2] |-> ##2 !timer_irq [*3]; endproperty
    a_halt: assert property (p_halt) else $error("irq after halt");
    property p_idle; idle == 5'h14 |-> !timer_irq; endproperty
    a_idle: assert property (p_idle) else $error("irq while stopped");
    property p_timer_pin; s_calm |-> pulse_output_pin == port_latch_bit; endproperty
    a_timer_pin: assert property (p_timer_pin) else $error("pin not following latch");
    property p_wave_irq; mode_q == 2'h1 && timer_irq |-> pulse_output_pin != $past(pulse_output_pin); endproperty
    a_wave_irq: assert property (p_wave_irq) else $error("irq without toggle");
endmodule // drtw_timer_assertions
`default_nettype wire

// ### tb_drtw_timer.sv
// self-checking testbench for the dual reload timer
`timescale 1ns/1ps
`default_nettype none
`include "drtw_defs.vh"
module tb_drtw_timer;
    localparam logic [11:0] RUN = `DRTW_OFF_RUN, PIN = `DRTW_OFF_PINCTL, MOD = `DRTW_OFF_MODE;
    localparam logic [11:0] PRE = `DRTW_OFF_PRESCALE, PRI = `DRTW_OFF_PRIMARY, SEC = `DRTW_OFF_SECONDARY;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic port_latch_bit = 1'b0;
    logic [1:0] cdiv = 2'h0;
    logic [15:0] n;
    logic [1:0] lv;
    int div [4] = '{1, 8, 4, 2};
    int bad_count = 0;
    int checked = 0;
    wire [7:0] reg_rdata;
    wire pulse_output_pin;
    wire timer_irq;
    always #2.5 core_clk = ~core_clk;
    // companion ticks every fourth cycle
    always @(posedge core_clk) cdiv <= cdiv + 2'h1;
    drtw_timer dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .companion_underflow(cdiv[1]),
        .port_latch_bit(port_latch_bit), .pulse_output_pin(pulse_output_pin), .timer_irq(timer_irq));
    task automatic chk(input string what, input int exp, input logic [15:0] got);
        checked++;
        if (got !== exp[15:0]) begin
            bad_count++;
            $display("[FAIL] %s expected %h got %h", what, exp[15:0], got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rchk(input string what, input logic [11:0] a, input int exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(what, exp, {8'h00, reg_rdata});
    endtask
    // cycles to the next irq, or to the next pin change; bounded so a dead timer cannot hang
    task automatic upto(input logic pin);
        logic p0;
        p0 = pulse_output_pin;
        n = 16'h0000;
        do begin
            @(posedge core_clk);
            #1 n = n + 16'h0001;
        end while (n < 16'h0190 && (pin ? pulse_output_pin === p0 : timer_irq !== 1'b1));
    endtask
    task automatic results;
        $display("compares %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rchk("pinctl reset", PIN, 8'h00);
        wr(PIN, 8'hFF);
        rchk("pinctl bits", PIN, 8'h0F);
        wr(MOD, 8'h3F);
        rchk("mode bits", MOD, 8'h3B);
        rchk("unmapped", 12'h100, 8'h00);
        wr(RUN, 8'h05);
        rchk("halt reads zero", RUN, 8'h00);
        wr(PIN, 8'h00);
        wr(MOD, 8'h00);
        wr(PRE, 8'h02);
        wr(PRI, 8'h03);
        wr(SEC, 8'h04);
        rchk("prescale", PRE, 8'h02);
        rchk("primary", PRI, 8'h03);
        rchk("secondary", SEC, 8'h04);
        @(posedge core_clk) port_latch_bit <= 1'b1;
        repeat (6) @(posedge core_clk);
        #1 chk("timer pin", 1, {15'h0000, pulse_output_pin});
        for (int i = 0; i < 4; i++) begin
            wr(MOD, {2'h0, i[1:0], 4'h0});
            wr(RUN, 8'h01);
            upto(1'b0);
            upto(1'b0);
            chk("period", 12 * div[i], n);
            wr(RUN, 8'h04);
        end
        wr(MOD, 8'h08);
        wr(RUN, 8'h01);
        upto(1'b0);
        wr(PRI, 8'h07);
        upto(1'b0);
        upto(1'b0);
        chk("reload only", 24, n);
        wr(RUN, 8'h04);
        wr(MOD, 8'h00);
        wr(RUN, 8'h01);
        rchk("status flag", RUN, 8'h03);
        upto(1'b0);
        wr(PRI, 8'h01);
        upto(1'b0);
        upto(1'b0);
        chk("write through", 6, n);
        wr(RUN, 8'h04);
        wr(MOD, 8'h01);
        wr(PRE, 8'h01);
        wr(PRI, 8'h02);
        for (int k = 0; k < 2; k++) begin
            wr(PIN, k[0] ? 8'h01 : 8'h00);
            wr(RUN, 8'h01);
            upto(1'b0);
            lv[k] = pulse_output_pin;
            upto(1'b1);
            chk("primary span", 6, n);
            upto(1'b1);
            chk("secondary span", 10, n);
            chk("irq at toggle", 1, {15'h0000, timer_irq});
            wr(RUN, 8'h04);
        end
        chk("level select", 1, {15'h0000, lv[0] ^ lv[1]});
        results;
    end
    initial begin
        #50000;
        bad_count++;
        results;
    end
endmodule // tb_drtw_timer
bind drtw_timer drtw_timer_assertions u_chk (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port_latch_bit(port_latch_bit), .pulse_output_pin(pulse_output_pin), .timer_irq(timer_irq));
`default_nettype wire
